// file: axis_zero_return_stop_control_tb.sv
module axis_zero_return_stop_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, s, px, py, p0, pv, zp;
  logic        drx, dry, ope, bue, stx, dx, sty, dy, mrdy, bx, by, edf;
  logic [31:0] seed = 32'h0000_80E2;
  int          err_count, check_count;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  axzr_ctrl #(.STEP_CYC(4), .HOME_STEPS(8'h04)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_ready_x(drx), .drive_ready_y(dry), .op_err_in(ope), .bus_err_in(bue),
    .step_x(stx), .dir_x(dx), .step_y(sty), .dir_y(dy), .module_ready_flag(mrdy),
    .x_axis_busy_flag(bx), .y_axis_busy_flag(by), .error_detect_flag(edf));

  axzr_drive_model drv (
    .pclk(pclk), .presetn(presetn), .step_x(stx), .dir_x(dx), .step_y(sty),
    .dir_y(dy), .pos_x(px), .pos_y(py));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    s = 32'(pslverr);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task wl(input logic [31:0] v); apb(1'b1, 8'h00, v); endtask : wl
  task cyc(input int n); repeat (n) @(posedge pclk); endtask : cyc
  task ce; apb(1'b1, 8'h28, 32'h1); endtask : ce

  task wi;
    int k;
    k = 0;
    while ((bx | by) !== 1'b0 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k < 400), 32'h1);
  endtask : wi

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    err_count++;
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite, ope, bue, presetn} = 6'h0;
    paddr = 8'h0; pwdata = 32'h0; drx = 1'b1; dry = 1'b1;
    cyc(20);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0); chk(r, 32'h0000_0100);
    apb(1'b0, 8'h40, 32'h0); chk(r, 32'h0); chk(s, 32'h1);
    $display("reset and map done");
    wl(32'h1);
    pv = rnd() & 32'h0000_0FFF;
    apb(1'b1, 8'h10, pv & 32'hFFFF); apb(1'b1, 8'h14, pv >> 16);
    apb(1'b0, 8'h10, 32'h0); chk(r, pv);
    apb(1'b1, 8'h14, 32'h1); apb(1'b0, 8'h10, 32'h0); chk(r, pv);
    apb(1'b0, 8'h28, 32'h0); chk(r, 32'h3C); chk(32'(edf), 32'h1);
    ce(); cyc(2); chk(32'(edf), 32'h0);
    $display("present value done");
    apb(1'b1, 8'h08, 32'h8000); apb(1'b1, 8'h0C, 32'h8000);
    wl(32'h3); cyc(40); chk(32'(bx), 32'h1);
    wl(32'h43); p0 = px; wl(32'h143); wi();
    chk(32'(px - p0 > 32'h2), 32'h1);
    wl(32'h3); cyc(20); chk(32'(bx), 32'h0);
    wl(32'h1C1); cyc(5); apb(1'b0, 8'h04, 32'h0); chk(r, 32'h100);
    wl(32'h1); wl(32'h9); cyc(40); chk(32'({bx, by}), 32'h3);
    wl(32'h89); wi();
    wl(32'h1); wl(32'h7); cyc(40); drx <= 1'b0; cyc(100);
    chk(32'({bx, by}), 32'h1);
    apb(1'b0, 8'h28, 32'h0); chk(r, 32'h46);
    drx <= 1'b1; wl(32'hC7); wi(); ce();
    $display("stop sources done");
    for (int k = 0; k < 2; k++) begin
      wl(32'h1); wl(32'h7); cyc(40);
      if (k == 1) bue <= 1'b1;
      else ope <= 1'b1;
      wi();
      apb(1'b0, 8'h28, 32'h0); chk({24'h0, r[7:0]}, k == 1 ? 32'h5A : 32'h47);
      {ope, bue} <= 2'h0; cyc(4); ce();
    end
    wl(32'h200); wl(32'h202); cyc(40); chk(32'(bx), 32'h1);
    wl(32'h302); cyc(40); chk(32'(bx), 32'h1);
    wl(32'h342); wi(); wl(32'h1);
    foreach (p0[i]) if (i < 3) begin
      wl(32'h1); wl(32'h2001 | (32'(i) << 10)); cyc(3);
      apb(1'b0, 8'h28, 32'h0); chk({24'h0, r[7:0]}, 32'h49); ce();
    end
    zp = rnd() & 32'h0000_0FFF;
    apb(1'b1, 8'h20, zp); wl(32'h1); wl(32'h11); cyc(4); wi();
    apb(1'b0, 8'h10, 32'h0); chk(r, zp);
    apb(1'b1, 8'h08, zp + 32'h2); apb(1'b1, 8'h2C, 32'h3412);
    wl(32'h1); wl(32'h3); cyc(4); wi();
    apb(1'b0, 8'h2C, 32'h0); chk(r, 32'h0001_0012);
    wl(32'h0); cyc(2);
    apb(1'b0, 8'h2C, 32'h0); chk(r, 32'h0);
    $display("restart and home done");
    wrap_up();
  end
endmodule : axis_zero_return_stop_control_tb

// file: axzr_ctrl.sv
// Added by the designer: the register addresses and the APB slave port.
`include "axzr_defines.svh"
// Contract
// R1 - host starts home only when interlocks clear
// R2 - host issues at most two home starts; the code sets no count and refuses a home start while hdone_r or started_r is set or hload_r is clear
// R3 - test mode skips controller ready check
// R4 - host writes present value only idle
// R5 - present value needs both words, else error
// R6 - home sets value to zero point
// R7 - valid stop decelerates busy axis
// R8 - stop during deceleration keeps decelerating
// R9 - starts act on rising edge only
// R10 - ready low clears code; stops drop active
// R11 - interpolated stop on either stops both
// R12 - after point update, independent stops
// R13 - drive not ready stops axis or pair
// R14 - operation or bus error stops both
// R15 - error stops decelerate and report code
// R16 - resume only absolute with auto switching
// R17 - test mode ignores common stop line
// R18 - errors write code and raise flag
// R19 - stops while idle do nothing
module axzr_ctrl #(
  parameter int         STEP_CYC   = `AXZR_STEP_CYC,
  parameter logic [7:0] VMAX       = `AXZR_VMAX,
  parameter logic [7:0] HOME_STEPS = `AXZR_HOME_STEPS
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // drive and fault pins
  input  wire logic        drive_ready_x,
  input  wire logic        drive_ready_y,
  input  wire logic        op_err_in,
  input  wire logic        bus_err_in,
  // pulse outputs
  output logic             step_x,
  output logic             dir_x,
  output logic             step_y,
  output logic             dir_y,
  // flags
  output logic             module_ready_flag,
  output logic             x_axis_busy_flag,
  output logic             y_axis_busy_flag,
  output logic             error_detect_flag
);

  function automatic logic sel_f(input logic [7:0] a, input logic [7:0] off);
    sel_f = (a == off);
  endfunction : sel_f

  // pin synchronisers
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {bus_err_in, op_err_in, drive_ready_y, drive_ready_x};
      pin_s2_r <= pin_s1_r;
    end
  end

  // step rate divider
  logic [15:0] div_r;
  wire         tick = (div_r == 16'(STEP_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= tick ? 16'h0000 : div_r + 16'h0001;
    end
  end

  // apb decode
  wire wr     = psel & penable & pwrite;
  wire s_line = sel_f(paddr, `AXZR_A_LINES);
  wire s_stat = sel_f(paddr, `AXZR_A_STAT);
  wire s_err  = sel_f(paddr, `AXZR_A_ERR);
  wire s_mc   = sel_f(paddr, `AXZR_A_MCODE);

  logic [`AXZR_LINES_W-1:0] lines_r;
  logic [`AXZR_LINES_W-1:0] lines_q_r;
  logic                     rdy_r;
  logic                     edf_r;
  logic                     interp_r;
  logic [31:0]              prdata_r;

  wire [`AXZR_LINES_W-1:0] rise = lines_r & ~lines_q_r;
  wire test    = lines_r[`AXZR_B_TEST];
  wire c_rdy   = lines_r[`AXZR_B_RDY];
  wire res_en  = lines_r[`AXZR_B_ABS] & lines_r[`AXZR_B_AUTO];
  wire sys_err = pin_s2_r[2] | pin_s2_r[3];
  wire erst    = wr & s_err & pwdata[0];
  wire mclr_w  = wr & s_mc & pwdata[`AXZR_B_MCLR];

  // per axis signals
  axzr_pkg::axzr_st_e    st_r      [2];
  axzr_pkg::axzr_flags_s fl        [2];
  logic [31:0]           pv_r      [2];
  logic [31:0]           tgt_r     [2];
  logic [31:0]           home_r    [2];
  logic [15:0]           plo_r     [2];
  logic [7:0]            spd_r     [2];
  logic [7:0]            hcnt_r    [2];
  logic [7:0]            err_r     [2];
  logic [7:0]            ecode     [2];
  logic [7:0]            mdata_r   [2];
  logic [7:0]            mcode_r   [2];
  logic [1:0]            busy;
  logic [1:0]            ok;
  logic [1:0]            go;
  logic [1:0]            hgo;
  logic [1:0]            sbad;
  logic [1:0]            hstop;
  logic [1:0]            drv_nr;
  logic [1:0]            stop_req;
  logic [1:0]            stev;
  logic [1:0]            pverr;
  logic [1:0]            eev;
  logic [1:0]            pu;
  logic [1:0]            homing_r;
  logic [1:0]            hdone_r;
  logic [1:0]            hload_r;
  logic [1:0]            started_r;
  logic [1:0]            mact_r;
  logic [1:0]            plo_pend_r;
  logic [1:0]            tnew_r;
  logic [1:0]            step_r;
  logic [1:0]            dir_r;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_ax
      localparam int O = 1 - i;
      wire [7:0] o_tgt = 8'(`AXZR_A_TGT + 4 * i);
      wire [7:0] o_pvl = 8'(`AXZR_A_PVL + 8 * i);
      wire [7:0] o_pvh = 8'(`AXZR_A_PVH + 8 * i);
      wire [7:0] o_hom = 8'(`AXZR_A_HOME + 4 * i);
      wire w_tgt = wr & sel_f(paddr, o_tgt);
      wire w_pvl = wr & sel_f(paddr, o_pvl);
      wire w_pvh = wr & sel_f(paddr, o_pvh);
      wire w_hom = wr & sel_f(paddr, o_hom);
      wire st_a  = rise[`AXZR_B_STA + i];
      wire st_c  = rise[`AXZR_B_STC];
      wire st_h  = rise[`AXZR_B_HOM + i];
      wire st_r2 = rise[`AXZR_B_RES];
      wire arrive = homing_r[i] ? (hcnt_r[i] == 8'h00) : (pv_r[i] == tgt_r[i]);
      wire up     = ~homing_r[i] & (tgt_r[i] > pv_r[i]);
      wire pv_ok  = w_pvh & plo_pend_r[i] & ~busy[i];
      wire mset   = (st_r[i] == axzr_pkg::AX_RUN) & ~stop_req[i] & tick & arrive
                  & ~pu[i] & ~homing_r[i];

      assign busy[i]   = (st_r[i] != axzr_pkg::AX_IDLE);
      assign drv_nr[i] = ~pin_s2_r[i];
      assign ok[i]     = rdy_r & (c_rdy | test) & ~busy[i] & ~mact_r[i] & ~drv_nr[i]; // R3
      assign go[i]     = ok[i] & (st_a | (st_c & ok[O]) | (st_r2 & res_en)); // R9 R16
      assign hgo[i]    = ok[i] & st_h & ~go[i] & ~started_r[i] & ~hdone_r[i] & hload_r[i]; // R6
      assign sbad[i]   = (st_a | st_c | st_h | st_r2) & ~go[i] & ~hgo[i]; // R16
      assign hstop[i]  = lines_r[`AXZR_B_STP + i] | (lines_r[`AXZR_B_CSTP] & ~test); // R17
      assign stop_req[i] = busy[i] & (hstop[i] | drv_nr[i] | sys_err // R19 R13 R14
                         | (interp_r & (hstop[O] | drv_nr[O]))); // R11 R12
      assign stev[i]   = stop_req[i] & (st_r[i] == axzr_pkg::AX_RUN); // R7
      assign pverr[i]  = (w_pvl & plo_pend_r[i]) | (w_pvh & ~plo_pend_r[i])
                       | (w_pvh & busy[i]); // R5
      assign pu[i]     = tick & (st_r[i] == axzr_pkg::AX_RUN) & ~stop_req[i] & arrive
                       & ~homing_r[i] & lines_r[`AXZR_B_AUTO] & tnew_r[i];
      assign eev[i]    = pverr[i] | sbad[i]
                       | (stev[i] & (drv_nr[i] | sys_err | (interp_r & drv_nr[O]))); // R15
      assign ecode[i]  = pverr[i] ? `AXZR_E_PV
                       : (sbad[i] & st_r2 & ~res_en) ? `AXZR_E_RESUME
                       : (sbad[i] & st_h) ? `AXZR_E_HOME
                       : sbad[i] ? `AXZR_E_START
                       : pin_s2_r[3] ? `AXZR_E_BUS
                       : pin_s2_r[2] ? `AXZR_E_OPE : `AXZR_E_DRV;
      assign fl[i]     = {mact_r[i], hdone_r[i], started_r[i], busy[i]};

      // host written values
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tgt_r[i]      <= 32'h0000_0000;
          home_r[i]     <= 32'h0000_0000;
          hload_r[i]    <= 1'b0;
          plo_r[i]      <= 16'h0000;
          plo_pend_r[i] <= 1'b0;
          mdata_r[i]    <= 8'h00;
          err_r[i]      <= `AXZR_E_NONE;
        end else begin
          if (w_tgt) begin
            tgt_r[i] <= pwdata;
          end
          if (w_hom) begin
            home_r[i]  <= pwdata;
            hload_r[i] <= 1'b1;
          end
          if (w_pvl & ~plo_pend_r[i]) begin
            plo_r[i] <= pwdata[15:0];
          end
          plo_pend_r[i] <= w_pvh ? 1'b0 : (w_pvl | plo_pend_r[i]); // R5
          if (wr & s_mc) begin
            mdata_r[i] <= pwdata[8*i +: 8];
          end
          err_r[i] <= eev[i] ? ecode[i] : (erst ? `AXZR_E_NONE : err_r[i]); // R18
        end
      end

      // axis motion
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_r[i]      <= axzr_pkg::AX_IDLE;
          spd_r[i]     <= 8'h00;
          pv_r[i]      <= 32'h0000_0000;
          hcnt_r[i]    <= 8'h00;
          homing_r[i]  <= 1'b0;
          hdone_r[i]   <= 1'b0;
          started_r[i] <= 1'b0;
          tnew_r[i]    <= 1'b0;
          mact_r[i]    <= 1'b0;
          mcode_r[i]   <= 8'h00;
          step_r[i]    <= 1'b0;
          dir_r[i]     <= 1'b0;
        end else begin
          step_r[i] <= 1'b0;
          tnew_r[i] <= w_tgt | (tnew_r[i] & ~pu[i] & ~go[i]);
          if (go[i]) begin
            started_r[i] <= 1'b1;
          end else if (~lines_r[`AXZR_B_STA + i] & ~lines_r[`AXZR_B_STC]) begin
            started_r[i] <= 1'b0;
          end
          if (pv_ok) begin
            pv_r[i] <= {pwdata[15:0], plo_r[i]}; // R5
          end
          unique case (st_r[i])
            axzr_pkg::AX_IDLE: begin
              if (go[i] | hgo[i]) begin
                st_r[i]     <= axzr_pkg::AX_RUN;
                spd_r[i]    <= 8'h01;
                homing_r[i] <= hgo[i];
                hcnt_r[i]   <= HOME_STEPS;
                hdone_r[i]  <= 1'b0;
              end
            end
            axzr_pkg::AX_RUN: begin
              if (stop_req[i]) begin
                st_r[i] <= axzr_pkg::AX_DECEL; // R7 R13 R14 R15
              end else if (tick & arrive & ~pu[i]) begin
                st_r[i]  <= axzr_pkg::AX_IDLE;
                spd_r[i] <= 8'h00;
                if (homing_r[i]) begin
                  pv_r[i]    <= home_r[i]; // R6
                  hdone_r[i] <= 1'b1;
                end else begin
                  mcode_r[i] <= mdata_r[i];
                  mact_r[i]  <= (mdata_r[i] != 8'h00);
                end
              end else if (tick & ~arrive) begin
                spd_r[i]  <= (spd_r[i] < VMAX) ? spd_r[i] + 8'h01 : spd_r[i];
                pv_r[i]   <= up ? pv_r[i] + 32'h1 : pv_r[i] - 32'h1;
                hcnt_r[i] <= homing_r[i] ? hcnt_r[i] - 8'h01 : hcnt_r[i];
                step_r[i] <= 1'b1;
                dir_r[i]  <= up;
              end
            end
            axzr_pkg::AX_DECEL: begin
              if (tick & (arrive | spd_r[i] <= 8'h01)) begin // R8
                st_r[i]  <= axzr_pkg::AX_IDLE;
                spd_r[i] <= 8'h00;
              end else if (tick) begin
                spd_r[i]  <= spd_r[i] - 8'h01;
                pv_r[i]   <= up ? pv_r[i] + 32'h1 : pv_r[i] - 32'h1;
                hcnt_r[i] <= homing_r[i] ? hcnt_r[i] - 8'h01 : hcnt_r[i];
                step_r[i] <= 1'b1;
                dir_r[i]  <= up;
              end
            end
            default: begin
              st_r[i] <= axzr_pkg::AX_IDLE;
            end
          endcase
          if (~c_rdy) begin
            mcode_r[i] <= 8'h00; // R10
            mact_r[i]  <= 1'b0;
          end else if (stev[i] | (mclr_w & ~mset)) begin
            mact_r[i] <= 1'b0; // R10
          end
        end
      end
    end
  endgenerate

  // shared control state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines_r   <= `AXZR_LINES_RST;
      lines_q_r <= `AXZR_LINES_RST;
      rdy_r     <= 1'b0;
      edf_r     <= 1'b0;
      interp_r  <= 1'b0;
    end else begin
      rdy_r     <= 1'b1;
      lines_q_r <= lines_r; // R9
      if (wr & s_line) begin
        lines_r <= pwdata[`AXZR_LINES_W-1:0];
      end
      edf_r <= (|eev) ? 1'b1 : (erst ? 1'b0 : edf_r); // R18
      if (go[0] & go[1] & rise[`AXZR_B_STC]) begin
        interp_r <= 1'b1; // R11
      end else if (|go) begin
        interp_r <= 1'b0;
      end else if (|pu) begin
        interp_r <= interp_r & ~lines_r[`AXZR_B_SEG]; // R12
      end
    end
  end

  // read path
  wire [7:0] rsel = paddr;
  wire hit = s_line | s_stat | s_err | s_mc | (rsel >= `AXZR_A_TGT & rsel <= `AXZR_A_PVH + 8'h08)
           | sel_f(rsel, `AXZR_A_HOME) | sel_f(rsel, `AXZR_A_HOME + 8'h04);
  wire [31:0] stat = {21'h0, interp_r, edf_r, rdy_r, fl[1], fl[0]};
  wire [31:0] rmux =
      s_line ? 32'(lines_r)
    : s_stat ? stat
    : sel_f(rsel, `AXZR_A_TGT) ? tgt_r[0]
    : sel_f(rsel, `AXZR_A_TGT + 8'h04) ? tgt_r[1]
    : sel_f(rsel, `AXZR_A_PVL) ? {16'h0, pv_r[0][15:0]}
    : sel_f(rsel, `AXZR_A_PVH) ? {16'h0, pv_r[0][31:16]}
    : sel_f(rsel, `AXZR_A_PVL + 8'h08) ? {16'h0, pv_r[1][15:0]}
    : sel_f(rsel, `AXZR_A_PVH + 8'h08) ? {16'h0, pv_r[1][31:16]}
    : sel_f(rsel, `AXZR_A_HOME) ? home_r[0]
    : sel_f(rsel, `AXZR_A_HOME + 8'h04) ? home_r[1]
    : s_err ? {16'h0, err_r[1], err_r[0]}
    : s_mc ? {14'h0, mact_r, mcode_r[1], mcode_r[0]}
    : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prdata_r <= rmux;
    end
  end

  assign prdata            = prdata_r;
  assign pready            = 1'b1;
  assign pslverr           = psel & penable & ~hit;
  assign step_x            = step_r[0];
  assign dir_x             = dir_r[0];
  assign step_y            = step_r[1];
  assign dir_y             = dir_r[1];
  assign module_ready_flag = rdy_r;
  assign x_axis_busy_flag  = busy[0];
  assign y_axis_busy_flag  = busy[1];
  assign error_detect_flag = edf_r;

endmodule : axzr_ctrl

// file: axzr_ctrl_props.sv
module axzr_ctrl_props #(
  parameter int STEP_CYC = 100
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        drive_ready_x,
  input wire logic        op_err_in,
  input wire logic        bus_err_in,
  input wire logic        step_x,
  // flags
  input wire logic        module_ready_flag,
  input wire logic        x_axis_busy_flag,
  input wire logic        y_axis_busy_flag,
  input wire logic        error_detect_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] wr_age_r;
  int         gap_r;
  wire        acc = psel && penable;
  // cycles since last control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_age_r <= 4'hF;
    else if (acc && pwrite && paddr == 8'h00) wr_age_r <= 4'h0;
    else if (wr_age_r != 4'hF) wr_age_r <= wr_age_r + 4'h1;
  end
  // cycles since last x step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_r <= STEP_CYC;
    else if (step_x) gap_r <= 0;
    else if (gap_r < STEP_CYC) gap_r <= gap_r + 1;
  end
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  property p_err_acc; pslverr |-> acc; endproperty
  a_err_acc: assert property (p_err_acc) else $error("pslverr outside access");
  property p_unmap; acc && !pwrite && paddr == 8'h40 |-> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
  property p_start; $rose(x_axis_busy_flag) |-> wr_age_r <= 4'h4; endproperty
  a_start: assert property (p_start) else $error("x start without command");
  property p_gap; step_x |-> gap_r >= STEP_CYC - 1; endproperty
  a_gap: assert property (p_gap) else $error("x steps too close");
  property p_clr;
    $fell(error_detect_flag) |-> $past(acc && pwrite && paddr == 8'h28 && pwdata[0]);
  endproperty
  a_clr: assert property (p_clr) else $error("error flag dropped alone");
  property p_drv; x_axis_busy_flag && !drive_ready_x |-> ##[1:150] !x_axis_busy_flag; endproperty
  a_drv: assert property (p_drv) else $error("x not stopped on drive loss");
  property p_flag; $fell(drive_ready_x) && x_axis_busy_flag |-> ##[1:5] error_detect_flag; endproperty
  a_flag: assert property (p_flag) else $error("drive loss not flagged");
  property p_ope;
    (op_err_in || bus_err_in) && (x_axis_busy_flag || y_axis_busy_flag)
      |-> ##[1:150] (!x_axis_busy_flag && !y_axis_busy_flag);
  endproperty
  a_ope: assert property (p_ope) else $error("fault did not stop both");
  property p_mrdy; module_ready_flag |=> module_ready_flag; endproperty
  a_mrdy: assert property (p_mrdy) else $error("module ready dropped");
endmodule : axzr_ctrl_props

bind axzr_ctrl axzr_ctrl_props #(.STEP_CYC(STEP_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drive_ready_x(drive_ready_x), .op_err_in(op_err_in), .bus_err_in(bus_err_in),
  .step_x(step_x), .module_ready_flag(module_ready_flag),
  .x_axis_busy_flag(x_axis_busy_flag), .y_axis_busy_flag(y_axis_busy_flag),
  .error_detect_flag(error_detect_flag)
);

// file: axzr_defines.svh
`ifndef AXZR_DEFINES_SVH
`define AXZR_DEFINES_SVH
// register byte offsets
`define AXZR_A_LINES 8'h00
`define AXZR_A_STAT  8'h04
`define AXZR_A_TGT   8'h08
`define AXZR_A_PVL   8'h10
`define AXZR_A_PVH   8'h14
`define AXZR_A_HOME  8'h20
`define AXZR_A_ERR   8'h28
`define AXZR_A_MCODE 8'h2C
// control line bit positions and width, and the mcode register clear bit
`define AXZR_B_RDY  0
`define AXZR_B_STA  1
`define AXZR_B_STC  3
`define AXZR_B_HOM  4
`define AXZR_B_STP  6
`define AXZR_B_CSTP 8
`define AXZR_B_TEST 9
`define AXZR_B_ABS  10
`define AXZR_B_AUTO 11
`define AXZR_B_SEG  12
`define AXZR_B_RES  13
`define AXZR_LINES_W 14
`define AXZR_B_MCLR 16
// reset values
`define AXZR_LINES_RST 14'h0000
// error codes
`define AXZR_E_NONE   8'h00
`define AXZR_E_PV     8'h3C
`define AXZR_E_DRV    8'h46
`define AXZR_E_OPE    8'h47
`define AXZR_E_START  8'h48
`define AXZR_E_RESUME 8'h49
`define AXZR_E_HOME   8'h4A
`define AXZR_E_BUS    8'h5A
// timing
`define AXZR_CLK_MHZ 100
`define AXZR_STEP_NS 1000
`define AXZR_STEP_CYC ((`AXZR_STEP_NS * `AXZR_CLK_MHZ) / 1000)
`define AXZR_VMAX 8'h10
`define AXZR_HOME_STEPS 8'h40
`endif

// file: axzr_drive_model.sv
module axzr_drive_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // pulse train
  input  wire logic        step_x,
  input  wire logic        dir_x,
  input  wire logic        step_y,
  input  wire logic        dir_y,
  // counted position
  output logic      [31:0] pos_x,
  output logic      [31:0] pos_y
);
  timeunit 1ns;
  timeprecision 1ps;
  // motor position follows each step pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_x <= 32'h0;
      pos_y <= 32'h0;
    end else begin
      if (step_x) pos_x <= dir_x ? pos_x + 32'h1 : pos_x - 32'h1;
      if (step_y) pos_y <= dir_y ? pos_y + 32'h1 : pos_y - 32'h1;
    end
  end
endmodule : axzr_drive_model

// file: axzr_pkg.sv
package axzr_pkg;
  typedef enum logic [1:0] {
    AX_IDLE,
    AX_RUN,
    AX_DECEL
  } axzr_st_e;
  typedef struct packed {
    logic mcode_act;
    logic home_done;
    logic started;
    logic busy;
  } axzr_flags_s;
endpackage : axzr_pkg
